// ### fifo_area_dev.sv
// FIFO RAM area manager with write port and endpoint-0 descriptor reply engine.
// Function
// - Each port has its own partitioned FIFO RAM.
// - Six areas with programmable start/end pointers.
// - CBW area: 32 bytes, 31 used, 0x0000.
// - CSW area: 16 bytes, 13 used, 0x0020.
// - Fixed areas serve host channel a, device bulk.
// - Attach bits join endpoint/channel to area.
// - Never attach one endpoint to two areas.
// - Area clear bit empties the fill count.
// - Clear leaves RAM contents untouched.
// - Descriptor reply only for endpoint 0 IN.
// - Write pointer advances by bytes written.
// - Write port reads back as zero.
// - Arm with pointer, length, go, IN direction.
// - Clear setup protect before clearing forced NAK.
// - Reply packets capped at endpoint-0 max packet.
// - Short packet when remainder below max.
// - OUT during reply clears go, sets done.
// - Firmware then moves to status stage.
// - Descriptor may sit in any free RAM.
// - Write port never changes fill counts.
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`default_nettype none
module fifo_area_dev (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  fifo_link_if.dev                  link,
  input  wire logic                 host_mode,
  input  wire logic                 usb_in_token,
  input  wire logic                 usb_out_token,
  input  wire logic [2:0]           usb_ep,
  input  wire logic                 usb_push,
  input  wire fifo_area_pkg::byte_t usb_push_data,
  input  wire logic                 usb_pop,
  output logic                      pop_valid_q,
  output fifo_area_pkg::byte_t      pop_data_q,
  output logic                      tx_valid_q,
  output fifo_area_pkg::byte_t      tx_data_q,
  output logic                      tx_last_q,
  input  wire logic                 bo_start,
  input  wire logic                 bo_wr,
  input  wire fifo_area_pkg::byte_t bo_data,
  output logic                      bo_full_q
);
  import fifo_area_pkg::*;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} reply_state_e;

  byte_t        ram [RAM_BYTES];
  addr_t        start_q  [AREAS];
  addr_t        end_q    [AREAS];
  logic [EPS-1:0] attach_q [AREAS];
  cnt_t         count_q  [AREAS];
  addr_t        wofs_q   [AREAS];
  addr_t        rofs_q   [AREAS];
  addr_t        wptr_q;
  addr_t        desc_start_q;
  len_t         desc_len_q;
  logic [3:0]   ep0_ctrl_q;
  len_t         ep0_max_q;
  logic         done_q;
  reply_state_e state_q;
  addr_t        dptr_q;
  len_t         remain_q;
  len_t         pkt_left_q;
  addr_t        bo_ofs_q;
  logic         ack_q;
  data_t        rdata_q;
  logic         wr;
  logic         sel_hit;
  logic [2:0]   sel;
  logic         push_ok;
  logic         pop_ok;
  logic         reply_ok;
  logic         out_hit;
  data_t        rd;
  addr_t        bo_limit;

  function automatic logic at_reg(reg_addr_t a, reg_addr_t base, int i);
    return a == reg_addr_t'(int'(base) + i);
  endfunction

  function automatic addr_t next_ofs(addr_t ofs, addr_t s, addr_t e);
    return (ofs == addr_t'(e - s)) ? '0 : addr_t'(ofs + 12'h001);
  endfunction

  assign wr       = link.req & link.we;
  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;

  // Pick the area joined to usb_ep.
  always_comb
  begin
    sel_hit = 1'b0;
    sel     = '0;
    for (int i = 0; i < AREAS; i++)
    begin
      if (usb_ep < 3'(EPS) && attach_q[i][usb_ep])
      begin
        sel_hit = 1'b1;
        sel     = 3'(i);
      end
    end
  end

  assign push_ok = usb_push & sel_hit &
                   ({1'b0, end_q[sel] - start_q[sel]} >= count_q[sel]);
  assign pop_ok  = usb_pop & sel_hit & (count_q[sel] != '0);

  for (genvar g = 0; g < AREAS; g++)
  begin : g_area
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        start_q[g]  <= '0;
        end_q[g]    <= '0;
        attach_q[g] <= '0;
      end
      else if (wr)
      begin
        if (at_reg(link.addr, REG_AREA_START, g))
          start_q[g] <= link.wdata[ADDR_W-1:0];
        if (at_reg(link.addr, REG_AREA_END, g))
          end_q[g] <= link.wdata[ADDR_W-1:0];
        if (at_reg(link.addr, REG_ATTACH, g))
          attach_q[g] <= link.wdata[EPS-1:0];
      end
    end

    // Clearing touches only the bookkeeping; the RAM keeps its bytes.
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        count_q[g] <= '0;
        wofs_q[g]  <= '0;
        rofs_q[g]  <= '0;
      end
      else if (wr && link.addr == REG_CLEAR && link.wdata[g])
      begin
        count_q[g] <= '0;
        wofs_q[g]  <= '0;
        rofs_q[g]  <= '0;
      end
      else
      begin
        if (push_ok && sel == 3'(g))
          wofs_q[g] <= next_ofs(wofs_q[g], start_q[g], end_q[g]);
        if (pop_ok && sel == 3'(g))
          rofs_q[g] <= next_ofs(rofs_q[g], start_q[g], end_q[g]);
        count_q[g] <= count_q[g] + cnt_t'(push_ok && sel == 3'(g))
                      - cnt_t'(pop_ok && sel == 3'(g));
      end
    end
  end

  assign bo_limit = host_mode ? CSW_USED : CBW_USED;

  // One RAM for the port; the register write port and bulk-only writes never touch the fill counts.
  always_ff @(posedge clk)
  begin
    if (wr && link.addr == REG_WPORT)
    begin
      if (link.be[0])
        ram[wptr_q] <= link.wdata[7:0];
      if (link.be[1])
        ram[link.be[0] ? addr_t'(wptr_q + 12'h001) : wptr_q] <= link.wdata[15:8];
    end
    if (push_ok)
      ram[addr_t'(start_q[sel] + wofs_q[sel])] <= usb_push_data;
    if (bo_wr && !bo_full_q)
      ram[addr_t'((host_mode ? CSW_BASE : CBW_BASE) + bo_ofs_q)] <= bo_data;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pop_valid_q <= 1'b0;
      pop_data_q  <= '0;
    end
    else
    begin
      pop_valid_q <= pop_ok;
      if (pop_ok)
        pop_data_q <= ram[addr_t'(start_q[sel] + rofs_q[sel])];
    end
  end

  // Bulk-only receive into CBW in device mode, CSW in host mode.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bo_ofs_q  <= '0;
      bo_full_q <= 1'b0;
    end
    else if (bo_start)
    begin
      bo_ofs_q  <= '0;
      bo_full_q <= 1'b0;
    end
    else if (bo_wr && !bo_full_q)
    begin
      bo_ofs_q  <= addr_t'(bo_ofs_q + 12'h001);
      bo_full_q <= (addr_t'(bo_ofs_q + 12'h001) == bo_limit);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wptr_q <= '0;
    else if (wr && link.addr == REG_WPTR)
      wptr_q <= link.wdata[ADDR_W-1:0];
    else if (wr && link.addr == REG_WPORT)
      wptr_q <= addr_t'(wptr_q + addr_t'(link.be[0]) + addr_t'(link.be[1]));
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      desc_start_q <= '0;
      desc_len_q   <= '0;
      ep0_max_q    <= EP0_MAX_RST;
    end
    else if (wr)
    begin
      if (link.addr == REG_DESC_START)
        desc_start_q <= link.wdata[ADDR_W-1:0];
      if (link.addr == REG_DESC_LEN)
        desc_len_q <= link.wdata;
      if (link.addr == REG_EP0_MAX)
        ep0_max_q <= link.wdata;
    end
  end

  assign out_hit = usb_out_token && usb_ep == EP_ZERO && ep0_ctrl_q[EP0_GO];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ep0_ctrl_q <= EP0_CTRL_RST;
    else
    begin
      if (wr && link.addr == REG_EP0_CTRL)
        ep0_ctrl_q <= link.wdata[3:0];
      if (out_hit)
        ep0_ctrl_q[EP0_GO] <= 1'b0;
    end
  end

  // A new done event wins over a software clear.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      done_q <= 1'b0;
    else if (out_hit)
      done_q <= 1'b1;
    else if (wr && link.addr == REG_EP0_STAT && link.wdata[0])
      done_q <= 1'b0;
  end

  // Send only when armed, unmasked and unprotected.
  assign reply_ok = ep0_ctrl_q[EP0_GO] & ep0_ctrl_q[EP0_DIR_IN] &
                    ~ep0_ctrl_q[EP0_NAK] & ~ep0_ctrl_q[EP0_PROTECT];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q    <= ST_IDLE;
      dptr_q     <= '0;
      remain_q   <= '0;
      pkt_left_q <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q  <= '0;
      tx_last_q  <= 1'b0;
    end
    else if (wr && link.addr == REG_EP0_CTRL && link.wdata[EP0_GO])
    begin
      state_q    <= ST_IDLE;
      dptr_q     <= desc_start_q;
      remain_q   <= desc_len_q;
      tx_valid_q <= 1'b0;
      tx_last_q  <= 1'b0;
    end
    else
    begin
      tx_valid_q <= 1'b0;
      tx_last_q  <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (usb_in_token && usb_ep == EP_ZERO && reply_ok && remain_q != '0 &&
              ep0_max_q != '0)
          begin
            pkt_left_q <= (remain_q < ep0_max_q) ? remain_q : ep0_max_q;
            state_q    <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          tx_valid_q <= 1'b1;
          tx_data_q  <= ram[dptr_q];
          tx_last_q  <= (pkt_left_q == 16'h0001);
          dptr_q     <= addr_t'(dptr_q + 12'h001);
          remain_q   <= len_t'(remain_q - 16'h0001);
          pkt_left_q <= len_t'(pkt_left_q - 16'h0001);
          if (pkt_left_q == 16'h0001)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    rd = '0;
    case (link.addr)
      REG_WPTR:       rd = data_t'(wptr_q);
      REG_DESC_START: rd = data_t'(desc_start_q);
      REG_DESC_LEN:   rd = desc_len_q;
      REG_EP0_CTRL:   rd = data_t'(ep0_ctrl_q);
      REG_EP0_MAX:    rd = ep0_max_q;
      REG_EP0_STAT:   rd = data_t'(done_q);
      REG_WPORT:      rd = '0;
      default:        rd = '0;
    endcase
    for (int i = 0; i < AREAS; i++)
    begin
      if (at_reg(link.addr, REG_AREA_START, i))
        rd = data_t'(start_q[i]);
      if (at_reg(link.addr, REG_AREA_END, i))
        rd = data_t'(end_q[i]);
      if (at_reg(link.addr, REG_ATTACH, i))
        rd = data_t'(attach_q[i]);
      if (at_reg(link.addr, REG_AREA_COUNT, i))
        rd = data_t'(count_q[i]);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q   <= link.req;
      rdata_q <= (link.req && !link.we) ? rd : '0;
    end
  end
endmodule
`default_nettype wire

// ### fifo_area_pkg.sv
// Constants and types shared by both ends.
`default_nettype none
package fifo_area_pkg;
  localparam int ADDR_W    = 12;
  localparam int RAM_BYTES = 4096;
  localparam int AREAS     = 6;
  localparam int EPS       = 6;
  localparam int REG_W     = 6;
  localparam int CNT_W     = 13;
  localparam int LEN_W     = 16;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [7:0]        byte_t;
  typedef logic [15:0]       data_t;
  typedef logic [REG_W-1:0]  reg_addr_t;
  typedef logic [CNT_W-1:0]  cnt_t;
  typedef logic [LEN_W-1:0]  len_t;

  // Register indices; the Avalon word address is the same.
  localparam reg_addr_t REG_AREA_START = 6'h00;
  localparam reg_addr_t REG_AREA_END   = 6'h08;
  localparam reg_addr_t REG_ATTACH     = 6'h10;
  localparam reg_addr_t REG_CLEAR      = 6'h18;
  localparam reg_addr_t REG_WPTR       = 6'h19;
  localparam reg_addr_t REG_WPORT      = 6'h1a;
  localparam reg_addr_t REG_DESC_START = 6'h1b;
  localparam reg_addr_t REG_DESC_LEN   = 6'h1c;
  localparam reg_addr_t REG_EP0_CTRL   = 6'h1d;
  localparam reg_addr_t REG_EP0_MAX    = 6'h1e;
  localparam reg_addr_t REG_EP0_STAT   = 6'h1f;
  localparam reg_addr_t REG_AREA_COUNT = 6'h20;
  localparam reg_addr_t REG_CTL_STATUS = 6'h3f;

  // Fixed bulk-only areas.
  localparam addr_t CBW_BASE  = 12'h000;
  localparam addr_t CBW_SIZE  = 12'h020;
  localparam addr_t CBW_USED  = 12'h01f;
  localparam addr_t CSW_BASE  = 12'h020;
  localparam addr_t CSW_SIZE  = 12'h010;
  localparam addr_t CSW_USED  = 12'h00d;
  localparam addr_t FIXED_END = CSW_BASE + CSW_SIZE;

  // Endpoint-0 control bit positions.
  localparam int EP0_GO      = 0;
  localparam int EP0_DIR_IN  = 1;
  localparam int EP0_NAK     = 2;
  localparam int EP0_PROTECT = 3;
  localparam logic [3:0] EP0_CTRL_RST = 4'hc;
  localparam len_t       EP0_MAX_RST  = 16'h0040;
  localparam logic [2:0] EP_ZERO      = 3'h0;
endpackage
`default_nettype wire

// ### fifo_link_if.sv
// Register link between the controller and the FIFO area manager.
`default_nettype none
interface fifo_link_if;
  import fifo_area_pkg::*;
  logic      req;
  logic      we;
  reg_addr_t addr;
  data_t     wdata;
  logic [1:0] be;
  logic      ack;
  data_t     rdata;
  modport dev (input req, input we, input addr, input wdata, input be,
               output ack, output rdata);
  modport ctl (output req, output we, output addr, output wdata, output be,
               input ack, input rdata);
endinterface
`default_nettype wire

// ### fifo_area_ctl.sv
// Avalon-MM controller that screens and forwards accesses to the area manager.
`default_nettype none
module fifo_area_ctl (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  fifo_link_if.ctl                      link,
  input  wire fifo_area_pkg::reg_addr_t avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest
);
  import fifo_area_pkg::*;

  typedef enum logic [2:0] {S_IDLE = 3'b001, S_WAIT = 3'b010, S_DONE = 3'b100} ctl_state_e;

  ctl_state_e     state_q;
  logic           req_q;
  logic           we_q;
  reg_addr_t      addr_q;
  data_t          wdata_q;
  logic [1:0]     be_q;
  logic           refused_q;
  logic [EPS-1:0] attach_sh_q [AREAS];
  addr_t          start_sh_q  [AREAS];
  logic [3:0]     ctrl_sh_q;
  logic           refuse;
  data_t          d;

  assign link.req   = req_q;
  assign link.we    = we_q;
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;
  assign link.be    = be_q;
  assign d          = avs_writedata[15:0];

  // Refuse writes that break the firmware rules.
  always_comb
  begin
    refuse = 1'b0;
    if (avs_write)
    begin
      for (int i = 0; i < AREAS; i++)
      begin
        if (avs_address == reg_addr_t'(int'(REG_ATTACH) + i))
        begin
          for (int j = 0; j < AREAS; j++)
            if (j != i && (attach_sh_q[j] & d[EPS-1:0]) != '0)
              refuse = 1'b1;
          if (d[EPS-1:0] != '0 && start_sh_q[i] < FIXED_END)
            refuse = 1'b1;
        end
      end
      if (avs_address == REG_EP0_CTRL)
      begin
        if (d[EP0_GO] && !d[EP0_DIR_IN])
          refuse = 1'b1;
        if (!d[EP0_NAK] && ctrl_sh_q[EP0_NAK] && ctrl_sh_q[EP0_PROTECT])
          refuse = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q         <= S_IDLE;
      req_q           <= 1'b0;
      we_q            <= 1'b0;
      addr_q          <= '0;
      wdata_q         <= '0;
      be_q            <= '0;
      avs_readdata    <= '0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if ((avs_read || avs_write) && (avs_address == REG_CTL_STATUS || refuse))
          begin
            avs_readdata    <= {31'h0, refused_q};
            avs_waitrequest <= 1'b0;
            state_q         <= S_DONE;
          end
          else if (avs_read || avs_write)
          begin
            req_q   <= 1'b1;
            we_q    <= avs_write;
            addr_q  <= avs_address;
            wdata_q <= d;
            be_q    <= avs_byteenable[1:0];
            state_q <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          req_q <= 1'b0;
          if (link.ack)
          begin
            avs_readdata    <= {16'h0, link.rdata};
            avs_waitrequest <= 1'b0;
            state_q         <= S_DONE;
          end
        end
        S_DONE:
        begin
          avs_waitrequest <= 1'b1;
          state_q         <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Sticky refused flag; a new refusal wins over a clear.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      refused_q <= 1'b0;
    else if (state_q == S_IDLE && avs_write && refuse && avs_address != REG_CTL_STATUS)
      refused_q <= 1'b1;
    else if (state_q == S_IDLE && avs_write && avs_address == REG_CTL_STATUS && d[0])
      refused_q <= 1'b0;
  end

  for (genvar g = 0; g < AREAS; g++)
  begin : g_shadow
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        attach_sh_q[g] <= '0;
        start_sh_q[g]  <= '0;
      end
      else if (state_q == S_IDLE && avs_write && !refuse)
      begin
        if (avs_address == reg_addr_t'(int'(REG_ATTACH) + g))
          attach_sh_q[g] <= d[EPS-1:0];
        if (avs_address == reg_addr_t'(int'(REG_AREA_START) + g))
          start_sh_q[g] <= d[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_sh_q <= EP0_CTRL_RST;
    else if (state_q == S_IDLE && avs_write && !refuse && avs_address == REG_EP0_CTRL)
      ctrl_sh_q <= d[3:0];
  end
endmodule
`default_nettype wire

// ### fifo_area_assertions.sv
// Concurrent checks on the controller-to-manager register link.
`default_nettype none
module fifo_area_assertions (
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic                     req,
  input wire logic                     we,
  input wire fifo_area_pkg::reg_addr_t addr,
  input wire fifo_area_pkg::data_t     wdata,
  input wire logic [1:0]               be,
  input wire logic                     ack,
  input wire fifo_area_pkg::data_t     rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import fifo_area_pkg::*;
  addr_t          st_q [AREAS];
  logic [EPS-1:0] at_q [AREAS];
  logic [3:0]     ctrl_q;
  logic           rd_q;
  reg_addr_t      ra_q;
  logic [EPS-1:0] others;
  logic           att_wr;
  logic           ctrl_wr;
  assign att_wr  = req && we && addr >= REG_ATTACH && addr < REG_ATTACH + 6'h6;
  assign ctrl_wr = req && we && addr == REG_EP0_CTRL && be[0];
  always_comb
  begin
    others = '0;
    for (int i = 0; i < AREAS; i++)
    begin
      if (addr[2:0] != 3'(i))
        others = others | at_q[i];
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      for (int i = 0; i < AREAS; i++)
      begin
        st_q[i] <= '0;
        at_q[i] <= '0;
      end
    else if (req && we && addr < 6'h06)
      st_q[addr[2:0]] <= wdata[ADDR_W-1:0];
    else if (att_wr)
      at_q[addr[2:0]] <= wdata[EPS-1:0];
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_q <= EP0_CTRL_RST;
    else if (ctrl_wr)
      ctrl_q <= wdata[3:0];
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_q <= 1'b0;
      ra_q <= '0;
    end
    else if (req)
    begin
      rd_q <= !we;
      ra_q <= addr;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_ack_after_req: assert property (req |=> ack ##0 !req)
    else $error("no ack after req");
  a_no_stray_ack: assert property (ack |-> $past(req))
    else $error("stray ack");
  a_req_spacing: assert property (req |=> !req [*2])
    else $error("req too close");
  a_write_rdata_zero: assert property (ack && !rd_q |-> rdata == 16'h0)
    else $error("write rdata nonzero");
  a_wport_reads_zero: assert property (ack && rd_q && ra_q == REG_WPORT |-> rdata == 16'h0)
    else $error("write port readable");
  a_clear_reads_zero: assert property (ack && rd_q && ra_q == REG_CLEAR |-> rdata == 16'h0)
    else $error("clear readable");
  a_start_readback: assert property (ack && rd_q && ra_q < 6'h06 |-> rdata == {4'h0, st_q[ra_q[2:0]]})
    else $error("bad start readback");
  a_go_needs_in: assert property (ctrl_wr && wdata[EP0_GO] |-> wdata[EP0_DIR_IN])
    else $error("go without IN");
  a_nak_after_protect: assert property (ctrl_wr && ctrl_q[EP0_NAK] && ctrl_q[EP0_PROTECT] |-> wdata[EP0_NAK])
    else $error("NAK cleared under protect");
  a_attach_unique: assert property (att_wr |-> (wdata[EPS-1:0] & others) == '0)
    else $error("double attach");
  a_attach_start: assert property (att_wr && wdata[EPS-1:0] != '0 |-> st_q[addr[2:0]] >= FIXED_END)
    else $error("attach over fixed areas");
endmodule
`default_nettype wire

// ### usb_fifo_area_manager_tb_top.sv
// Self-checking bench for the FIFO area manager and its controller.
`default_nettype none
module usb_fifo_area_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fifo_area_pkg::*;
  typedef struct { logic w; reg_addr_t a; data_t d; logic [3:0] be; } row_s;
  logic        clk = 1'b0, resetn = 1'b0, host_mode = 1'b0, usb_in_token = 1'b0;
  logic        usb_out_token = 1'b0, usb_push = 1'b0, usb_pop = 1'b0, bo_start = 1'b0;
  logic        bo_wr = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [2:0]  usb_ep = 3'h0;
  byte_t       usb_push_data = 8'h9f, bo_data = 8'h00, pop_data_q, tx_data_q;
  logic        pop_valid_q, tx_valid_q, tx_last_q, bo_full_q, avs_waitrequest;
  reg_addr_t   avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [8:0]  txq [$];
  byte_t       popq [$];
  logic [8:0]  txe [5] = '{9'h011, 9'h122, 9'h033, 9'h144, 9'h155};
  int          n_mismatch = 0, cmp_count = 0;
  row_s rows [17] = '{
    '{1, REG_AREA_START, 16'h0100, 4'h3}, '{0, REG_AREA_START, 16'h0100, 4'h3},
    '{1, REG_AREA_END, 16'h0103, 4'h3}, '{0, REG_AREA_END, 16'h0103, 4'h3},
    '{1, REG_WPTR, 16'h0300, 4'h3}, '{0, REG_WPTR, 16'h0300, 4'h3},
    '{1, REG_WPORT, 16'h2211, 4'h3}, '{1, REG_WPORT, 16'h4433, 4'h3},
    '{1, REG_WPORT, 16'h0055, 4'h1}, '{0, REG_WPORT, 16'h0000, 4'h3},
    '{0, REG_WPTR, 16'h0305, 4'h3}, '{1, REG_DESC_START, 16'h0300, 4'h3},
    '{0, REG_DESC_START, 16'h0300, 4'h3}, '{1, REG_DESC_LEN, 16'h0005, 4'h3},
    '{1, REG_EP0_MAX, 16'h0002, 4'h3}, '{0, REG_EP0_MAX, 16'h0002, 4'h3},
    '{0, 6'h30, 16'h0000, 4'h3}};
  fifo_link_if i_fifo_link_if ();
  fifo_area_ctl i_fifo_area_ctl (.clk(clk), .resetn(resetn), .link(i_fifo_link_if),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fifo_area_dev i_fifo_area_dev (.clk(clk), .resetn(resetn), .link(i_fifo_link_if),
    .host_mode(host_mode), .usb_in_token(usb_in_token), .usb_out_token(usb_out_token),
    .usb_ep(usb_ep), .usb_push(usb_push), .usb_push_data(usb_push_data), .usb_pop(usb_pop),
    .pop_valid_q(pop_valid_q), .pop_data_q(pop_data_q), .tx_valid_q(tx_valid_q),
    .tx_data_q(tx_data_q), .tx_last_q(tx_last_q), .bo_start(bo_start), .bo_wr(bo_wr),
    .bo_data(bo_data), .bo_full_q(bo_full_q));
  fifo_area_assertions i_fifo_area_assertions (.clk(clk), .resetn(resetn),
    .req(i_fifo_link_if.req), .we(i_fifo_link_if.we), .addr(i_fifo_link_if.addr),
    .wdata(i_fifo_link_if.wdata), .be(i_fifo_link_if.be), .ack(i_fifo_link_if.ack),
    .rdata(i_fifo_link_if.rdata));
  always #20 clk = ~clk;
  // Collects descriptor and popped bytes where they are settled.
  always @(negedge clk)
  begin
    if (tx_valid_q === 1'b1)
      txq.push_back({tx_last_q, tx_data_q});
    if (pop_valid_q === 1'b1)
      popq.push_back(pop_data_q);
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("cmp %0d mismatch %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic avx(input logic w, input reg_addr_t a, input data_t d, input logic [3:0] be,
                     output logic [31:0] rq);
    int n;
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= {16'h0, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    chk("answer", {31'h0, avs_waitrequest}, 32'h0);
  endtask
  task automatic wr(input reg_addr_t a, input data_t d);
    avx(1'b1, a, d, 4'h3, q);
  endtask
  task automatic rdc(input reg_addr_t a, input data_t e);
    avx(1'b0, a, 16'h0, 4'h3, q);
    chk($sformatf("reg %h", a), q, {16'h0, e});
  endtask
  task automatic pulse(input int n, input logic pop);
    repeat (n)
    begin
      @(posedge clk);
      usb_push      <= !pop;
      usb_pop       <= pop;
      usb_push_data <= usb_push_data + 8'h1;
    end
    @(posedge clk);
    usb_push <= 1'b0;
    usb_pop  <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic tok(input logic in, input logic [2:0] ep);
    @(posedge clk);
    usb_ep        <= ep;
    usb_in_token  <= in;
    usb_out_token <= !in;
    @(posedge clk);
    usb_in_token  <= 1'b0;
    usb_out_token <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic bo_bytes(input int n);
    repeat (n)
    begin
      @(posedge clk);
      bo_wr   <= 1'b1;
      bo_data <= bo_data + 8'h1;
    end
    @(posedge clk);
    bo_wr <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rdc(REG_EP0_CTRL, 16'h000c);
    foreach (rows[i])
    begin
      avx(rows[i].w, rows[i].a, rows[i].d, rows[i].be, q);
      if (!rows[i].w)
        chk("table read", q, {16'h0, rows[i].d});
    end
    $display("test register table done");
    wr(REG_ATTACH, 16'h0002);
    usb_ep <= 3'h1;
    pulse(5, 1'b0);
    rdc(REG_AREA_COUNT, 16'h0004);
    wr(REG_WPTR, 16'h0200);
    wr(REG_WPORT, 16'h7777);
    rdc(REG_AREA_COUNT, 16'h0004);
    pulse(1, 1'b1);
    chk("pop byte", {24'h0, popq[0]}, 32'h000000a0);
    wr(REG_ATTACH + 6'h1, 16'h0004);
    rdc(REG_CTL_STATUS, 16'h0001);
    rdc(REG_ATTACH + 6'h1, 16'h0000);
    wr(REG_CTL_STATUS, 16'h0001);
    wr(REG_AREA_START + 6'h2, 16'h0200);
    wr(REG_ATTACH + 6'h2, 16'h0002);
    rdc(REG_CTL_STATUS, 16'h0001);
    wr(REG_CTL_STATUS, 16'h0001);
    wr(REG_CLEAR, 16'h003f);
    rdc(REG_AREA_COUNT, 16'h0000);
    pulse(1, 1'b1);
    chk("empty pop", popq.size(), 32'h1);
    $display("test area fifo done");
    wr(REG_EP0_CTRL, 16'h000d);
    rdc(REG_CTL_STATUS, 16'h0001);
    rdc(REG_EP0_CTRL, 16'h000c);
    wr(REG_CTL_STATUS, 16'h0001);
    wr(REG_EP0_CTRL, 16'h000f);
    wr(REG_EP0_CTRL, 16'h000b);
    rdc(REG_CTL_STATUS, 16'h0001);
    rdc(REG_EP0_CTRL, 16'h000f);
    wr(REG_EP0_CTRL, 16'h0007);
    tok(1'b1, 3'h0);
    chk("nak reply", txq.size(), 32'h0);
    wr(REG_EP0_CTRL, 16'h0003);
    tok(1'b1, 3'h1);
    chk("ep1 reply", txq.size(), 32'h0);
    repeat (4) tok(1'b1, 3'h0);
    chk("reply count", txq.size(), 32'h5);
    for (int i = 0; i < 5; i++)
      chk("reply byte", {23'h0, txq[i]}, {23'h0, txe[i]});
    tok(1'b0, 3'h0);
    rdc(REG_EP0_CTRL, 16'h0002);
    rdc(REG_EP0_STAT, 16'h0001);
    wr(REG_EP0_STAT, 16'h0001);
    rdc(REG_EP0_STAT, 16'h0000);
    $display("test descriptor reply done");
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      host_mode <= m[0];
      bo_start  <= 1'b1;
      @(posedge clk);
      bo_start <= 1'b0;
      bo_bytes((m == 1) ? int'(CSW_USED) - 1 : int'(CBW_USED) - 1);
      chk("bulk full early", {31'h0, bo_full_q}, 32'h0);
      bo_bytes(2);
      chk("bulk full", {31'h0, bo_full_q}, 32'h1);
    end
    $display("test bulk-only areas done");
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdc(REG_EP0_CTRL, 16'h000c);
    rdc(REG_EP0_MAX, 16'h0040);
    rdc(REG_AREA_START, 16'h0000);
    rdc(REG_WPTR, 16'h0000);
    rdc(REG_CTL_STATUS, 16'h0000);
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
